// ---- design/step_direction_indexer.v ----
`timescale 1ns/1ps
`include "step_indexer_defs.vh"
// ----------------------------------------
// Function
// - indexer mode only when indexer_select high
// - switch low means input reads low
// - driver_hold_low low holds drivers reset
// - driver_doze_low low puts drivers asleep
// - run request rise enables both drivers
// - run request fall disables both drivers
// - direction rise selects forward sequencing
// - direction fall selects reverse sequencing
// - each step rise outside indexer reset, except one in the clear-rise cycle, advances one microstep
// - position clear rise enters indexer reset
// - drivers disabled while indexer in reset
// - position clear fall leaves indexer reset
// - index is zero on leaving reset
// - select code picks 512 down to 4
// - select, hold, doze act immediately
// - mode selects sampled only at reset
// ----------------------------------------
module step_direction_indexer (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // indexer header pins
    input wire run_pin,
    input wire dir_pin,
    input wire step_pin,
    input wire clear_pin,
    // secondary header pins and their preset switches
    input wire [`USM_W-1:0] usm_pin,
    input wire [`USM_W-1:0] usm_switch,
    input wire hold_pin,
    input wire hold_switch,
    input wire doze_pin,
    input wire doze_switch,
    // mode straps
    input wire indexer_select,
    input wire host_link_select_low,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // driver controls
    output reg driver_enable,
    output reg driver_hold_low,
    output reg driver_doze_low,
    output reg [`INDEX_W-1:0] step_index,
    output reg [`USM_W-1:0] microstep_select
);
    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    wire [4:0] raw;
    wire [4:0] lvl;
    wire [4:0] rise;
    wire [4:0] fall;
    // switches are asynchronous too, so they are gated before the synchroniser
    assign raw = {doze_pin & doze_switch, hold_pin & hold_switch, clear_pin, step_pin, dir_pin};
    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_sync
            input_sync u_sync (
                .clk(clk),
                .rst_b(rst_b),
                .pin(raw[i]),
                .level(lvl[i]),
                .rise(rise[i]),
                .fall(fall[i])
            );
        end
    endgenerate
    wire run_rise;
    wire run_fall;
    input_sync u_run (
        .clk(clk),
        .rst_b(rst_b),
        .pin(run_pin),
        .level(),
        .rise(run_rise),
        .fall(run_fall)
    );
    wire [`USM_W-1:0] usm_lvl;
    generate
        for (i = 0; i < `USM_W; i = i + 1) begin : g_usm
            input_sync u_usm (
                .clk(clk),
                .rst_b(rst_b),
                .pin(usm_pin[i] & usm_switch[i]),
                .level(usm_lvl[i]),
                .rise(),
                .fall()
            );
        end
    endgenerate

    // ----------------------------------------
    // straps and register state
    // ----------------------------------------
    reg indexer_mode;
    reg link_mode_low;
    reg strap_pending;
    reg [7:0] ctrl;
    reg forward;
    reg index_reset;
    wire [`INDEX_W-1:0] next_index;

    // straps caught one edge after reset release, held until next reset
    always @(posedge clk) begin
        if (!rst_b) begin
            strap_pending <= 1'b1;
            indexer_mode <= 1'b0;
            link_mode_low <= 1'b1;
        end else if (strap_pending) begin
            strap_pending <= 1'b0;
            indexer_mode <= indexer_select;
            link_mode_low <= host_link_select_low;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    wire acc;
    wire addr_ok;
    assign acc = psel & penable;
    assign addr_ok = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS) || (paddr == `ADDR_INDEX);
    assign pready = 1'b1;
    assign pslverr = acc & ~addr_ok;

    always @(posedge clk) begin
        if (!rst_b) begin
            ctrl <= `CTRL_RESET;
        end else if (acc && pwrite && paddr == `ADDR_CTRL) begin
            ctrl <= pwdata[7:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `ADDR_CTRL: prdata <= {24'h000000, ctrl};
                `ADDR_STATUS: prdata <= {27'h0000000, ~link_mode_low, indexer_mode, index_reset, forward,
                                         driver_enable};
                `ADDR_INDEX: prdata <= {21'h000000, step_index};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // indexer core
    // ----------------------------------------
    wire [`USM_W-1:0] usm_eff;
    wire hold_in;
    wire doze_in;
    // serial mode takes settings from the control register instead
    assign usm_eff = indexer_mode ? usm_lvl : ctrl[`CTRL_USM_MSB:`CTRL_USM_LSB];
    assign hold_in = indexer_mode ? lvl[3] : ctrl[`CTRL_HOLD_BIT];
    assign doze_in = indexer_mode ? lvl[4] : ctrl[`CTRL_DOZE_BIT];

    step_advance u_adv (
        .index(step_index),
        .usm(usm_eff),
        .forward(forward),
        .next_index(next_index)
    );

    always @(posedge clk) begin
        if (!rst_b) begin
            driver_enable <= 1'b0;
            forward <= 1'b1;
            index_reset <= 1'b0;
            step_index <= {`INDEX_W{1'b0}};
            driver_hold_low <= 1'b0;
            driver_doze_low <= 1'b0;
            microstep_select <= {`USM_W{1'b0}};
        end else begin
            driver_hold_low <= hold_in;
            driver_doze_low <= doze_in;
            microstep_select <= usm_eff;
            if (indexer_mode) begin
                if (rise[2]) begin
                    index_reset <= 1'b1;
                end else if (fall[2]) begin
                    index_reset <= 1'b0;
                    step_index <= {`INDEX_W{1'b0}};
                end
                if (rise[0]) begin
                    forward <= 1'b1;
                end else if (fall[0]) begin
                    forward <= 1'b0;
                end
                if (index_reset || rise[2]) begin
                    driver_enable <= 1'b0;
                end else if (run_rise) begin
                    driver_enable <= 1'b1;
                end else if (run_fall) begin
                    driver_enable <= 1'b0;
                end
                // a step in the clear-fall cycle would override the zeroing
                if (rise[1] && !index_reset && !rise[2] && !fall[2]) begin
                    step_index <= next_index;
                end
            end else begin
                driver_enable <= 1'b0;
            end
        end
    end
endmodule

// ---- design/step_indexer_defs.vh ----
`ifndef STEP_INDEXER_DEFS_VH
`define STEP_INDEXER_DEFS_VH

// ----------------------------------------
// apb register map (byte addresses)
// ----------------------------------------
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_INDEX 12'h008

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_USM_LSB 0
`define CTRL_USM_MSB 2
`define CTRL_HOLD_BIT 4
`define CTRL_DOZE_BIT 5
`define CTRL_MODE_BIT 6
`define CTRL_LINK_BIT 7
`define CTRL_RESET 8'h30

// ----------------------------------------
// status register fields
// ----------------------------------------
`define STAT_ENABLE_BIT 0
`define STAT_DIR_BIT 1
`define STAT_IDXRST_BIT 2
`define STAT_INDEXER_BIT 3
`define STAT_LINK_BIT 4

// ----------------------------------------
// index geometry
// ----------------------------------------
`define INDEX_W 11
`define USM_W 3

`endif

// ---- design/input_sync.v ----
`timescale 1ns/1ps
// three-stage synchroniser with edge detection
module input_sync (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // pin side
    input wire pin,
    // synchronised side
    output reg level,
    output reg rise,
    output reg fall
);
    reg s1;
    reg s2;
    reg s3;

    // change counts once stages two and three agree
    always @(posedge clk) begin
        if (!rst_b) begin
            // keep filling in reset, so a pin already high is not seen as an edge
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= s3;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            rise <= 1'b0;
            fall <= 1'b0;
            if (s2 == s3 && s3 != level) begin
                level <= s3;
                rise <= s3;
                fall <= ~s3;
            end
        end
    end
endmodule

// ---- design/step_advance.v ----
`timescale 1ns/1ps
`include "step_indexer_defs.vh"
// next index for one step at the selected resolution
module step_advance (
    // current state
    input wire [`INDEX_W-1:0] index,
    input wire [`USM_W-1:0] usm,
    input wire forward,
    // result
    output wire [`INDEX_W-1:0] next_index
);
    // 2048 entries per electrical cycle; 512 microsteps per full step quarter
    wire [`INDEX_W-1:0] stride;
    assign stride = {{(`INDEX_W-1){1'b0}}, 1'b1} << usm;
    assign next_index = forward ? index + stride : index - stride;
endmodule

// ---- testbench/sdi_monitor.sv ----
`timescale 1ns/1ps
`include "step_indexer_defs.vh"
module sdi_monitor (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // pins
    input wire run_pin,
    input wire step_pin,
    input wire clear_pin,
    input wire [`USM_W-1:0] usm_pin,
    input wire [`USM_W-1:0] usm_switch,
    input wire hold_pin,
    input wire hold_switch,
    input wire indexer_select,
    // driver side
    input wire driver_enable,
    input wire driver_hold_low,
    input wire [`INDEX_W-1:0] step_index,
    input wire [`USM_W-1:0] microstep_select
);
    // ----------------------------------------
    // strap copy, latched at the first edge out of reset
    // ----------------------------------------
    reg first;
    reg mode;
    wire [`INDEX_W-1:0] unit = 11'h1 << microstep_select;
    always @(posedge clk) begin
        first <= !rst_b;
        if (first && rst_b)
            mode <= indexer_select;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    run_enable_a: assert property ($rose(run_pin) && mode ##1 (run_pin && !clear_pin)[*7] |-> driver_enable)
        else $error("drivers not enabled after run request");
    run_disable_a: assert property ($fell(run_pin) ##1 (!run_pin)[*7] |-> !driver_enable)
        else $error("drivers still enabled after run release");
    clear_disable_a: assert property (clear_pin[*8] |-> !driver_enable)
        else $error("drivers enabled during index reset");
    clear_freeze_a: assert property (clear_pin[*8] |-> $stable(step_index))
        else $error("index moved during index reset");
    clear_zero_a: assert property ($fell(clear_pin) && !step_pin && mode
        ##1 (!clear_pin && !step_pin)[*7] |-> step_index == 0)
        else $error("index not zero after index reset");
    step_unit_a: assert property ($changed(step_index) && $stable(microstep_select)
        && step_index != 0 |-> step_index - $past(step_index) == unit || $past(step_index) - step_index == unit)
        else $error("step size does not match resolution");
    hold_follow_a: assert property (($stable(hold_pin && hold_switch) && mode)[*8]
        |-> driver_hold_low == (hold_pin && hold_switch))
        else $error("driver hold does not follow its pin");
    usm_follow_a: assert property (($stable(usm_pin & usm_switch) && mode)[*8]
        |-> microstep_select == (usm_pin & usm_switch))
        else $error("resolution does not follow its pins");
    serial_idle_a: assert property (!mode |-> !driver_enable)
        else $error("drivers enabled in serial mode");
endmodule
bind step_direction_indexer sdi_monitor i_mon (.clk(clk), .rst_b(rst_b), .run_pin(run_pin),
    .step_pin(step_pin), .clear_pin(clear_pin), .usm_pin(usm_pin), .usm_switch(usm_switch),
    .hold_pin(hold_pin), .hold_switch(hold_switch), .indexer_select(indexer_select),
    .driver_enable(driver_enable), .driver_hold_low(driver_hold_low), .step_index(step_index),
    .microstep_select(microstep_select));

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    // clock
    input wire clk,
    // indexer header
    output wire run_pin,
    output wire dir_pin,
    output wire step_pin,
    output wire clear_pin
);
    // ----------------------------------------
    // header levels
    // ----------------------------------------
    logic [3:0] pins = 4'h0;
    assign {clear_pin, step_pin, dir_pin, run_pin} = pins;
    // each level is held long enough to pass the synchroniser
    task automatic put(input int n, input logic v);
        @(posedge clk);
        pins[n] <= v;
        repeat (8) @(posedge clk);
    endtask
    task automatic step(input int k);
        repeat (k) begin
            put(2, 1'b1);
            put(2, 1'b0);
        end
    endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`include "step_indexer_defs.vh"
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] usm_pin = 3'h0;
    logic [2:0] usm_switch = 3'h7;
    logic hold_pin = 1'b1, hold_switch = 1'b1, doze_pin = 1'b1, doze_switch = 1'b1;
    logic indexer_select = 1'b1, link_low = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic run_pin, dir_pin, step_pin, clear_pin, pready, pslverr, err, driver_enable, hold_low, doze_low;
    logic [10:0] step_index, exp_idx;
    logic [2:0] microstep_select;
    int n_errors = 0, comparisons = 0;
    initial forever #25 clk = ~clk;
    host_model i_host (.clk(clk), .run_pin(run_pin), .dir_pin(dir_pin), .step_pin(step_pin), .clear_pin(clear_pin));
    step_direction_indexer i_dut (.clk(clk), .rst_b(rst_b), .run_pin(run_pin), .dir_pin(dir_pin),
        .step_pin(step_pin), .clear_pin(clear_pin), .usm_pin(usm_pin), .usm_switch(usm_switch),
        .hold_pin(hold_pin), .hold_switch(hold_switch), .doze_pin(doze_pin), .doze_switch(doze_switch),
        .indexer_select(indexer_select), .host_link_select_low(link_low), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .driver_enable(driver_enable), .driver_hold_low(hold_low), .driver_doze_low(doze_low),
        .step_index(step_index), .microstep_select(microstep_select));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run;
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic reset_dut;
        rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        reset_dut();
        apb(1'b0, `ADDR_CTRL, 32'h0);
        check(rd, 32'h30);
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[30:0], err}, 32'h1);
        i_host.put(1, 1'b1);
        exp_idx = 11'h0;
        // every resolution code, one forward step each
        for (int c = 0; c < 8; c++) begin
            usm_pin <= c[2:0];
            repeat (8) @(posedge clk);
            i_host.step(1);
            exp_idx += 11'h1 << c;
            check(step_index, exp_idx);
        end
        i_host.put(1, 1'b0);
        i_host.step(2);
        exp_idx -= 11'h100;
        apb(1'b0, `ADDR_INDEX, 32'h0);
        check(rd, exp_idx);
        i_host.put(1, 1'b1);
        i_host.step(1);
        exp_idx += 11'h80;
        check(step_index, exp_idx);
        usm_switch <= 3'h0;
        hold_switch <= 1'b0;
        doze_pin <= 1'b0;
        repeat (8) @(posedge clk);
        check({microstep_select, hold_low, doze_low}, 5'h0);
        usm_switch <= 3'h7;
        hold_switch <= 1'b1;
        doze_pin <= 1'b1;
        repeat (8) @(posedge clk);
        check({microstep_select, hold_low, doze_low}, 5'h1f);
        i_host.put(0, 1'b1);
        check(driver_enable, 1'b1);
        i_host.put(0, 1'b0);
        check(driver_enable, 1'b0);
        i_host.put(0, 1'b1);
        i_host.put(3, 1'b1);
        check(driver_enable, 1'b0);
        i_host.step(2);
        check(step_index, exp_idx);
        i_host.put(3, 1'b0);
        check(step_index, 11'h0);
        indexer_select <= 1'b0;
        link_low <= 1'b0;
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check(rd[4:3], 2'b01);
        reset_dut();
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check(rd[4:3], 2'b10);
        i_host.put(0, 1'b0);
        i_host.put(0, 1'b1);
        apb(1'b1, `ADDR_CTRL, 32'h05);
        repeat (8) @(posedge clk);
        check({driver_enable, microstep_select, hold_low, doze_low}, 6'h14);
        complete_run();
    end
endmodule
